// [flash_seq_defines.svh]
// constants of the flash command sequencer
// Notes on behaviour
// - divider register accepts one write per reset
// - divider writes ignored while access error set
// - pulses timed in whole timing clock periods
// - program 9 ticks, chained burst byte of the same row 4 ticks
// - page erase 4000, mass erase 20000 ticks
// - sequence starts with one latched array write
// - erase ignores data; page erase uses page
// - codes 05 blank, 20 program, 25 burst
// - codes 40 page, 41 mass; latch code
// - writing one to buffer-empty launches command
// - writing zero to buffer-empty aborts, flags error
// - command-complete flag shows command finished
// - erase never touches less than a page
// - error on array write when buffer full or repeated
// - error on unknown command code
// - error on control access after code written
// - error cleared by one; blocks all commands
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH

// bus map
`define PADDR_W 19
`define ARRAY_SEL_BIT 18
`define DIV_ADDR 19'h00000
`define STAT_ADDR 19'h00004
`define CMD_ADDR 19'h00008

// divider register fields
`define DIV_LOADED_BIT 7
`define DIV_PRESCALE_BIT 6
`define DIV_RESET 6'h00
`define PRESCALE_SHIFT 3

// status register fields
`define STAT_CBE_BIT 7
`define STAT_CCF_BIT 6
`define STAT_ACCERR_BIT 4
`define STAT_BLANK_BIT 2

// command codes
`define CODE_BLANK 8'h05
`define CODE_PROG 8'h20
`define CODE_BURST 8'h25
`define CODE_PAGE 8'h40
`define CODE_MASS 8'h41

// timing counts in timing clock periods
`define PROG_TICKS 16'h0009
`define BURST_TICKS 16'h0004
`define PAGE_ERASE_TICKS 16'h0fa0
`define MASS_ERASE_TICKS 16'h4e20
`define BLANK_TICKS 16'h0009

// address masks
`define PAGE_MASK 16'hfe00
`define ROW_MASK 16'h003f

`endif

// [flash_seq_pkg.sv]
// types of the flash command sequencer
package flash_seq_pkg;
  `include "flash_seq_defines.svh"

  typedef enum logic [7:0] {
    CMD_BLANK = `CODE_BLANK,
    CMD_PROG = `CODE_PROG,
    CMD_BURST = `CODE_BURST,
    CMD_PAGE = `CODE_PAGE,
    CMD_MASS = `CODE_MASS
  } cmd_code_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ADDR = 2'b01,
    SEQ_CMD = 2'b10
  } seq_state_t;

  typedef enum logic {
    EX_IDLE = 1'b0,
    EX_RUN = 1'b1
  } exec_state_t;

  typedef struct packed {
    logic [7:0] code;
    logic [15:0] addr;
    logic [7:0] data;
  } cmd_entry_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`PADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic active;
    logic hv_on;
    logic burst_tick;
    cmd_entry_t cmd;
  } flash_op_t;
endpackage

// [timing_clock_divider.sv]
// divider that makes the flash timing clock as a one-cycle tick
`timescale 1ns/10ps
module timing_clock_divider
  import flash_seq_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // settings
  input wire logic enable,
  input wire logic restart,
  input wire logic prescale,
  input wire logic [5:0] div_value,
  // timing clock
  output logic tick
);

  typedef struct packed {
    logic [9:0] cnt;
    logic tick;
  } div_regs_t;

  div_regs_t r;
  div_regs_t next_r;

  // period in ref_clk cycles, minus one
  function automatic logic [9:0] period_limit(input logic pre,
                                              input logic [5:0] v);
    logic [9:0] base;
    base = {4'h0, v} + 10'h001;
    if (pre) begin
      base = base << `PRESCALE_SHIFT;
    end
    period_limit = base - 10'h001;
  endfunction

  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    // restart aligns ticks with a pulse start so periods are whole
    if (!enable || restart) begin
      next_r.cnt = 10'h000;
    end else if (r.cnt >= period_limit(prescale, div_value)) begin
      next_r.cnt = 10'h000;
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = r.cnt + 10'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick = r.tick;

endmodule

// [pulse_timer.sv]
// counts a number of timing clock periods for one pulse
`timescale 1ns/10ps
module pulse_timer
  import flash_seq_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // control
  input wire logic load,
  input wire logic [15:0] count,
  input wire logic tick,
  // result
  output logic done
);

  typedef struct packed {
    logic busy;
    logic [15:0] cnt;
  } timer_regs_t;

  timer_regs_t r;
  timer_regs_t next_r;

  always_comb begin
    next_r = r;
    if (load) begin
      next_r.busy = 1'b1;
      next_r.cnt = count;
    end else if (done) begin
      next_r.busy = 1'b0;
      next_r.cnt = 16'h0000;
    end else if (r.busy && tick) begin
      next_r.cnt = r.cnt - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // done in the cycle of the last tick; a registered done would stretch
  // every pulse by one more bus cycle
  assign done = r.busy && tick && (r.cnt <= 16'h0001);

endmodule

// [flash_command_sequencer.sv]
// flash command interface and sequencer behind an apb slave
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
module flash_command_sequencer
  import flash_seq_pkg::*;
#(
  parameter logic [15:0] PAGE_TICKS = `PAGE_ERASE_TICKS,
  parameter logic [15:0] MASS_TICKS = `MASS_ERASE_TICKS
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register bus
  input wire apb_req_t apb_req,
  output apb_rsp_t apb_rsp,
  // flash array
  input wire logic array_blank,
  output flash_op_t flash_op
);

  typedef struct packed {
    seq_state_t seq;
    cmd_entry_t lat;
    logic q_valid;
    cmd_entry_t q;
    exec_state_t ex;
    cmd_entry_t run;
    logic chained;
    logic div_loaded;
    logic div_prescale;
    logic [5:0] div_value;
    logic acc_err;
    logic blank;
    logic [31:0] prdata;
  } seq_regs_t;

  seq_regs_t r;
  seq_regs_t next_r;

  logic tick;
  logic timer_done;
  logic timer_load;
  logic [15:0] timer_count;

  ////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic code_valid(input logic [7:0] c);
    code_valid = (c == CMD_BLANK) || (c == CMD_PROG) ||
                 (c == CMD_BURST) || (c == CMD_PAGE) ||
                 (c == CMD_MASS);
  endfunction

  // pulse length of a command in timing clock periods
  function automatic logic [15:0] ticks_for(input logic [7:0] c,
                                            input logic chain);
    unique case (c)
      CMD_PROG: ticks_for = `PROG_TICKS;
      CMD_BURST: ticks_for = chain ? `BURST_TICKS : `PROG_TICKS;
      CMD_PAGE: ticks_for = PAGE_TICKS;
      CMD_MASS: ticks_for = MASS_TICKS;
      default: ticks_for = `BLANK_TICKS;
    endcase
  endfunction

  // a burst skips the ramp only for the next byte of the same row
  function automatic logic row_continues(input cmd_entry_t cur,
                                         input cmd_entry_t nxt);
    logic [15:0] succ;
    succ = cur.addr + 16'h0001;
    row_continues = (cur.code == CMD_BURST) && (nxt.code == CMD_BURST) &&
                    (nxt.addr == succ) &&
                    ((succ & `ROW_MASK) != 16'h0000);
  endfunction

  // erase and blank check take no data; page erase acts on the page
  function automatic cmd_entry_t shape_entry(input cmd_entry_t e);
    cmd_entry_t o;
    o = e;
    if (e.code != CMD_PROG && e.code != CMD_BURST) begin
      o.data = 8'h00;
    end
    if (e.code == CMD_PAGE) begin
      o.addr = e.addr & `PAGE_MASK;
    end
    shape_entry = o;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // bus decode

  logic acc;
  logic setup;
  logic wr;
  logic is_arr;
  logic is_div;
  logic is_stat;
  logic is_cmd;
  logic is_ctrl;
  logic mapped;
  logic cbe;
  logic ccf;
  logic [15:0] arr_addr;

  assign acc = apb_req.psel && apb_req.penable;
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr = acc && apb_req.pwrite;
  assign is_arr = apb_req.paddr[`ARRAY_SEL_BIT] &&
                  (apb_req.paddr[1:0] == 2'h0);
  assign is_div = (apb_req.paddr == `DIV_ADDR);
  assign is_stat = (apb_req.paddr == `STAT_ADDR);
  assign is_cmd = (apb_req.paddr == `CMD_ADDR);
  assign is_ctrl = is_div || is_stat || is_cmd;
  assign mapped = is_arr || is_ctrl;
  assign arr_addr = apb_req.paddr[17:2];

  assign cbe = !r.q_valid;
  assign ccf = !r.q_valid && (r.ex == EX_IDLE);

  // zero wait states; read data was captured in the setup cycle
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = acc && !mapped;
  assign apb_rsp.prdata = r.prdata;

  ////////////////////////////////////////////////////////////////////
  // next state

  logic err_set;
  logic err_clr;
  logic [31:0] rd_value;

  always_comb begin
    next_r = r;
    err_set = 1'b0;
    err_clr = 1'b0;
    timer_load = 1'b0;
    timer_count = 16'h0000;
    rd_value = 32'h0000_0000;

    // read mux
    if (is_div) begin
      rd_value[`DIV_LOADED_BIT] = r.div_loaded;
      rd_value[`DIV_PRESCALE_BIT] = r.div_prescale;
      rd_value[5:0] = r.div_value;
    end else if (is_stat) begin
      rd_value[`STAT_CBE_BIT] = cbe;
      rd_value[`STAT_CCF_BIT] = ccf;
      rd_value[`STAT_ACCERR_BIT] = r.acc_err;
      rd_value[`STAT_BLANK_BIT] = r.blank;
    end else if (is_cmd) begin
      rd_value[7:0] = r.lat.code;
    end
    if (setup && !apb_req.pwrite) begin
      next_r.prdata = rd_value;
    end

    // error flag clears only on a written one
    if (wr && is_stat && apb_req.pwdata[`STAT_ACCERR_BIT]) begin
      err_clr = 1'b1;
    end

    // command sequence
    if (acc && is_ctrl && r.seq == SEQ_CMD && !(wr && is_stat)) begin
      // any other control access between code and launch
      err_set = 1'b1;
      next_r.seq = SEQ_IDLE;
    end else if (wr && is_arr) begin
      if (r.acc_err) begin
        next_r.seq = r.seq;
      end else if (!r.div_loaded || !cbe || r.seq != SEQ_IDLE) begin
        err_set = 1'b1;
        next_r.seq = SEQ_IDLE;
      end else begin
        next_r.lat.addr = arr_addr;
        next_r.lat.data = apb_req.pwdata[7:0];
        next_r.seq = SEQ_ADDR;
      end
    end else if (wr && is_cmd) begin
      if (r.acc_err) begin
        next_r.seq = r.seq;
      end else if (r.seq != SEQ_ADDR) begin
        err_set = 1'b1;
        next_r.seq = SEQ_IDLE;
      end else if (code_valid(apb_req.pwdata[7:0])) begin
        next_r.lat.code = apb_req.pwdata[7:0];
        next_r.seq = SEQ_CMD;
      end else begin
        err_set = 1'b1;
        next_r.seq = SEQ_IDLE;
      end
    end else if (wr && is_stat) begin
      if (!apb_req.pwdata[`STAT_CBE_BIT]) begin
        if (r.seq != SEQ_IDLE) begin
          err_set = 1'b1;
          next_r.seq = SEQ_IDLE;
        end
      end else if (r.seq == SEQ_CMD && !r.acc_err && cbe) begin
        next_r.q = shape_entry(r.lat);
        next_r.q_valid = 1'b1;
        next_r.blank = 1'b0;
        next_r.seq = SEQ_IDLE;
      end else if (r.seq == SEQ_ADDR) begin
        // launch without a code is a broken sequence
        err_set = 1'b1;
        next_r.seq = SEQ_IDLE;
      end
    end else if (wr && is_div) begin
      if (r.seq == SEQ_ADDR) begin
        err_set = 1'b1;
        next_r.seq = SEQ_IDLE;
      end else if (!r.div_loaded && !r.acc_err) begin
        next_r.div_loaded = 1'b1;
        next_r.div_prescale = apb_req.pwdata[`DIV_PRESCALE_BIT];
        next_r.div_value = apb_req.pwdata[5:0];
      end
    end

    // set wins over a clear in the same cycle
    next_r.acc_err = err_set || (r.acc_err && !err_clr);

    // executor
    unique case (r.ex)
      EX_IDLE: begin
        if (r.q_valid) begin
          next_r.run = r.q;
          next_r.q_valid = 1'b0;
          next_r.chained = 1'b0;
          next_r.ex = EX_RUN;
          timer_load = 1'b1;
          timer_count = ticks_for(r.q.code, 1'b0);
        end
      end
      EX_RUN: begin
        if (timer_done) begin
          if (r.run.code == CMD_BLANK) begin
            next_r.blank = array_blank;
          end
          if (r.q_valid) begin
            // a queued burst byte of the same row skips the ramp
            next_r.chained = row_continues(r.run, r.q);
            next_r.run = r.q;
            next_r.q_valid = 1'b0;
            timer_load = 1'b1;
            timer_count = ticks_for(r.q.code,
                                    row_continues(r.run, r.q));
          end else begin
            next_r.ex = EX_IDLE;
            next_r.chained = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
      r.seq <= SEQ_IDLE;
      r.ex <= EX_IDLE;
      r.div_value <= `DIV_RESET;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // timing clock and pulse timer

  timing_clock_divider u_divider (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .enable(r.div_loaded),
    .restart(timer_load),
    .prescale(r.div_prescale),
    .div_value(r.div_value),
    .tick(tick)
  );

  // pulses count whole periods of the divided clock
  pulse_timer u_timer (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .load(timer_load),
    .count(timer_count),
    .tick(tick),
    .done(timer_done)
  );

  ////////////////////////////////////////////////////////////////////
  // array side

  // high voltage stays up across a chained burst, so it follows run
  assign flash_op.active = (r.ex == EX_RUN);
  assign flash_op.hv_on = (r.ex == EX_RUN);
  assign flash_op.burst_tick = r.chained;
  assign flash_op.cmd = r.run;

endmodule

// [flash_array_model.sv]
// flash array stand-in: reports blank while no byte stays programmed
`timescale 1ns/10ps
module flash_array_model
  import flash_seq_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // array side
  input wire flash_op_t flash_op,
  output logic array_blank
);
  logic [15:0] used[$];
  logic was;
  cmd_entry_t prev;
  initial array_blank = 1'b1;
  ////////////////////////////////////////////////////////////////////////
  // a pulse acts once, at its rising edge
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      was <= 1'b0;
      prev <= '0;
    end else begin
      was <= flash_op.active;
      prev <= flash_op.cmd;
      // a queued command follows with no gap, so a new entry counts too
      if (flash_op.active && (!was || flash_op.cmd != prev)) begin
        case (flash_op.cmd.code)
          CMD_PROG, CMD_BURST: used.push_back(flash_op.cmd.addr);
          CMD_MASS: used.delete();
          CMD_PAGE: used = used.find(x) with
            (x[15:9] != flash_op.cmd.addr[15:9]);
          default: ;
        endcase
      end
      array_blank <= (used.size() == 0);
    end
  end
endmodule

// [flash_command_sequencer_props.sv]
// port assertions of the flash command sequencer
`timescale 1ns/10ps
module flash_command_sequencer_props
  import flash_seq_pkg::*;
#(
  parameter logic [15:0] PAGE_TICKS = 16'h0fa0,
  parameter logic [15:0] MASS_TICKS = 16'h4e20
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register bus
  input wire apb_req_t apb_req,
  input wire apb_rsp_t apb_rsp,
  // flash array
  input wire logic array_blank,
  input wire flash_op_t flash_op
);
  logic acc;
  logic mapped;
  assign acc = apb_req.psel && apb_req.penable;
  assign mapped = apb_req.paddr inside {19'h00000, 19'h00004, 19'h00008}
    || (apb_req.paddr[18] && apb_req.paddr[1:0] == 2'b00);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////
  a_ready_high: assert property (apb_rsp.pready)
    else $error("pready low");
  a_slverr_map: assert property (apb_rsp.pslverr == (acc && !mapped))
    else $error("pslverr wrong for address");
  a_hv_follows: assert property (flash_op.hv_on == flash_op.active)
    else $error("high voltage differs from active");
  a_page_aligned: assert property (flash_op.active &&
    flash_op.cmd.code == CMD_PAGE |-> flash_op.cmd.addr[8:0] == 9'h000)
    else $error("page erase address not aligned");
  a_erase_nodata: assert property (flash_op.active &&
    flash_op.cmd.code inside {CMD_BLANK, CMD_PAGE, CMD_MASS}
    |-> flash_op.cmd.data == 8'h00) else $error("erase carries data");
  a_code_known: assert property (flash_op.active |->
    flash_op.cmd.code inside {CMD_BLANK, CMD_PROG, CMD_BURST, CMD_PAGE,
    CMD_MASS}) else $error("unknown code running");
  a_prog_length: assert property ($rose(flash_op.active) &&
    flash_op.cmd.code == CMD_PROG |-> flash_op.active [*8])
    else $error("byte program too short");
  a_burst_tick: assert property (flash_op.burst_tick |->
    flash_op.active && flash_op.cmd.code == CMD_BURST)
    else $error("burst tick outside burst");
  c_page: cover property (flash_op.active && flash_op.cmd.code == CMD_PAGE);
  c_mass: cover property (flash_op.active && flash_op.cmd.code == CMD_MASS);
  c_slverr: cover property (apb_rsp.pslverr);
  c_burst: cover property (flash_op.burst_tick);
endmodule
bind flash_command_sequencer flash_command_sequencer_props #(
  .PAGE_TICKS(PAGE_TICKS), .MASS_TICKS(MASS_TICKS)) i_props (
  .ref_clk(ref_clk), .rst_b(rst_b), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .array_blank(array_blank), .flash_op(flash_op));

// [test_flash_command_sequencer.sv]
// self-checking bench of the flash command sequencer
`timescale 1ns/10ps
`define CHK(nm, e, s) begin \
  num_checks++; \
  if ((s) !== (e)) begin \
    errors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, s); \
  end \
end
module test_flash_command_sequencer;
  import flash_seq_pkg::*;
  localparam logic [18:0] DV = 19'h00000;
  localparam logic [18:0] ST = 19'h00004;
  localparam logic [18:0] CM = 19'h00008;
  localparam logic [18:0] AR = 19'h40000;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  apb_req_t apb_req = '0;
  apb_rsp_t apb_rsp;
  logic array_blank;
  flash_op_t flash_op;
  cmd_entry_t seen;
  cmd_entry_t exp;
  int errors = 0;
  int num_checks = 0;
  int seed = 13618;
  int run_len = 0;
  int blank_m = 0;
  int bt_len = 0;
  logic slv;
  logic [31:0] rd;
  logic [15:0] fa = 16'h0000;
  logic [7:0] fd = 8'h00;
  logic [15:0] progd[$];
  flash_command_sequencer #(.PAGE_TICKS(16'h0005), .MASS_TICKS(16'h0007))
    i_flash_command_sequencer (.ref_clk(ref_clk), .rst_b(rst_b),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .array_blank(array_blank),
    .flash_op(flash_op));
  flash_array_model i_flash_array_model (.ref_clk(ref_clk),
    .rst_b(rst_b), .flash_op(flash_op), .array_blank(array_blank));
  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (flash_op.active) begin
      run_len <= run_len + 1;
      seen <= flash_op.cmd;
    end
    if (flash_op.burst_tick) begin
      bt_len <= bt_len + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [18:0] a,
                      input logic [31:0] d);
    @(posedge ref_clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    do @(posedge ref_clk); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    slv = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  task automatic chk_err;
    xfer(0, ST, 0);
    `CHK("error flag set", 1'b1, rd[4])
    run_len = 0;
    xfer(1, ST, 32'h80);
    xfer(0, DV, 0);
    `CHK("launch ignored", 0, run_len)
    xfer(1, ST, 32'h10);
    xfer(0, ST, 0);
    `CHK("error flag clear", 1'b0, rd[4])
  endtask
  task automatic wait_done;
    int k;
    k = 0;
    do xfer(0, ST, 0); while (rd[6] !== 1'b1 && ++k < 100);
    if (rd[6] !== 1'b1) errors++;
  endtask
  // random address only for programming, so erases hit the last byte
  task automatic run(input logic [7:0] c, input int n);
    if (c inside {8'h20, 8'h25}) begin
      fa = 16'($random(seed));
      fd = 8'($random(seed));
    end
    xfer(1, AR | {1'b0, fa, 2'b00}, {24'h0, fd});
    xfer(1, CM, {24'h0, c});
    run_len = 0;
    xfer(1, ST, 32'h80);
    wait_done();
    `CHK("pulse length", 1'b1, run_len >= n && run_len <= n + 1)
    exp = '{c, (c == 8'h40) ? (fa & 16'hfe00) : fa,
      (c inside {8'h20, 8'h25}) ? fd : 8'h00};
    `CHK("running command", exp, seen)
    if (c inside {8'h20, 8'h25}) progd.push_back(fa);
    if (c == 8'h41) progd.delete();
    if (c == 8'h40) progd = progd.find(x) with (x[15:9] != fa[15:9]);
    blank_m = (c == 8'h05) && (progd.size() == 0);
    `CHK("status after", {2'b11, 3'b000, blank_m[0], 2'b00}, rd[7:0])
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    errors++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    xfer(0, ST, 0);
    `CHK("status reset", 8'hc0, rd[7:0])
    xfer(0, 19'h0000c, 0);
    `CHK("unmapped read", 32'h0, rd)
    `CHK("unmapped slave error", 1'b1, slv)
    xfer(1, AR, 32'h11);
    xfer(0, ST, 0);
    `CHK("write before divider", 1'b1, rd[4])
    xfer(1, DV, 32'h01);
    xfer(0, DV, 0);
    `CHK("divider locked out", 8'h00, rd[7:0])
    xfer(1, ST, 32'h10);
    xfer(1, DV, 32'h00);
    xfer(1, DV, 32'h3f);
    xfer(0, DV, 0);
    `CHK("divider once", 8'h80, rd[7:0])
    run(8'h20, 9);
    run(8'h05, 9);
    run(8'h40, 5);
    run(8'h05, 9);
    run(8'h25, 9);
    // next byte of the row queued inside the first byte's nine ticks
    fa = 16'h0100;
    xfer(1, AR | {1'b0, fa, 2'b00}, 32'h5a);
    xfer(1, CM, 32'h25);
    bt_len = 0;
    xfer(1, ST, 32'h80);
    fa = fa + 16'h0001;
    fd = 8'($random(seed));
    xfer(1, AR | {1'b0, fa, 2'b00}, {24'h0, fd});
    xfer(1, CM, 32'h25);
    xfer(1, ST, 32'h80);
    wait_done();
    `CHK("burst byte ticks", 1'b1, bt_len >= 4 && bt_len <= 5)
    `CHK("burst byte", {8'h25, fa, fd}, seen)
    `CHK("status after burst", 8'hc0, rd[7:0])
    progd.push_back(fa - 16'h0001);
    progd.push_back(fa);
    run(8'h41, 7);
    run(8'h05, 9);
    xfer(1, AR, 0);
    xfer(1, ST, 32'h0);
    chk_err();
    xfer(1, AR, 0);
    xfer(1, CM, 32'h33);
    chk_err();
    xfer(1, AR, 0);
    xfer(1, AR, 0);
    chk_err();
    xfer(1, AR, 0);
    xfer(1, CM, 32'h20);
    xfer(0, CM, 0);
    chk_err();
    close_out();
  end
endmodule
